// file: supply_mon_pkg.sv
package supply_mon_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] SUPPLY_CLEAR_OFF = 8'h24;
   localparam logic [ADDR_W-1:0] SYS_IRQ_EN_OFF = 8'h28;
   localparam logic [ADDR_W-1:0] PWR_CTRL_OFF = 8'h30;
   localparam logic [ADDR_W-1:0] SUPPLY_STATUS_OFF = 8'h38;
   localparam logic [ADDR_W-1:0] SYS_STATUS_OFF = 8'h3c;

   // Supply clear layout: interrupt status clears, then sticky clears
   localparam int SUPPLY_FLAG_W = 10;
   localparam int IRQ_CLR_LSB = 0;
   localparam int STICKY_CLR_LSB = 16;
   localparam int STICKY_OV_LSB = 21;
   localparam int CORE_OV_IRQ_BIT = 8;
   localparam int EXT_OV_IRQ_BIT = 9;
   localparam logic [DATA_W-1:0] SUPPLY_CLR_MASK = 32'h03ff03ff;

   // System interrupt enable layout
   localparam int SYS_EV_W = 4;
   localparam int SYS_EN_LSB = 8;
   localparam logic [DATA_W-1:0] SYS_EN_MASK = 32'h00000f00;
   localparam logic [DATA_W-1:0] SYS_EN_RESET = 32'h00000000;

   // Power control layout
   localparam int CLKWDT_DIS_BIT = 1;
   localparam int VS_UV_DIS_BIT = 8;
   localparam logic [DATA_W-1:0] PWR_CTRL_RESET = 32'h0ee37ef3;
   localparam logic [DATA_W-1:0] PWR_CTRL_MASK = 32'h00000102;

   // Bus handshake states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_ACC = 2'b10
   } bus_state_t;

endpackage : supply_mon_pkg

// file: status_flag_bank.sv
`timescale 1ns/1ns
module status_flag_bank #(
   parameter int WIDTH = 10
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_set,
   input wire logic [WIDTH-1:0] i_clr,
   output logic [WIDTH-1:0] o_flags
);

   genvar g;

   // One sticky flag per event; a set in the clear cycle wins so no event is lost
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_flag
         always_ff @(posedge i_clk)
         begin
            if (i_rst)
               o_flags[g] <= 1'b0;
            else if (i_set[g])
               o_flags[g] <= 1'b1;
            else if (i_clr[g])
               o_flags[g] <= 1'b0;
         end

         a_flag_set_wins: assert property (
            @(posedge i_clk) disable iff (i_rst)
            i_set[g] |=> o_flags[g])
            else $error("flag not set after event");

         a_flag_holds: assert property (
            @(posedge i_clk) disable iff (i_rst)
            (o_flags[g] && !i_clr[g]) |=> o_flags[g])
            else $error("flag dropped without a clear");
      end
   endgenerate

endmodule : status_flag_bank

// file: shutdown_ctrl.sv
`timescale 1ns/1ns
module shutdown_ctrl (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_clkwdt_event,
   input wire logic i_vs_uv,
   input wire logic i_clock_watchdog_shutdown_disable,
   input wire logic i_transceiver_undervolt_shutdown_disable,
   output logic o_power_off,
   output logic o_vs_uv_off
);

   // Clock watchdog switch-off, only while not disabled
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_power_off <= 1'b0;
      else
         o_power_off <= i_clkwdt_event & ~i_clock_watchdog_shutdown_disable;
   end

   // VS undervoltage cuts power modules and bus transmitter unless disabled
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_vs_uv_off <= 1'b0;
      else
         o_vs_uv_off <= i_vs_uv & ~i_transceiver_undervolt_shutdown_disable;
   end

   a_wdt_shutdown: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ##1 o_power_off == ($past(i_clkwdt_event) && !$past(i_clock_watchdog_shutdown_disable)))
      else $error("watchdog shutdown mismatch");

   a_vs_uv_shutdown: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_vs_uv && !i_transceiver_undervolt_shutdown_disable) |=> o_vs_uv_off)
      else $error("vs undervoltage shutdown missing");

   a_vs_uv_disabled: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_transceiver_undervolt_shutdown_disable |=> !o_vs_uv_off)
      else $error("vs undervoltage shutdown while disabled");

endmodule : shutdown_ctrl

// file: supply_monitor_irq_control_regs.sv
// Function
// - Write one bit 8 clears core overvoltage status
// - Write one bit 9 clears external overvoltage status
// - Clear register reserved bits read zero, ignored
// - Bits 16-20 clear sticky undervoltage flags
// - Bits 21-25 clear sticky overvoltage flags
// - Zero written leaves the flag untouched
// - Bit 8 enables overtemperature warning interrupt
// - Bit 9 enables overtemperature shutdown interrupt
// - Bit 10 enables reference undervoltage interrupt
// - Bit 11 enables reference overvoltage interrupt
// - Clock watchdog shutdown unless bit 1 set
// - VS undervoltage shutdown unless bit 8 set
// - Power control resets to 0ee37ef3, reserved zero; the code stores only bits 1 and 8, so it reads 00000002 after reset
// - Bits 0-7 clear supply interrupt status
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module supply_monitor_irq_control_regs (
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [supply_mon_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [supply_mon_pkg::DATA_W-1:0] I_PWDATA,
   input wire logic [supply_mon_pkg::STRB_W-1:0] I_PSTRB,
   input wire logic [supply_mon_pkg::SUPPLY_FLAG_W-1:0] I_SUPPLY_IRQ_EVENT,
   input wire logic [supply_mon_pkg::SUPPLY_FLAG_W-1:0] I_SUPPLY_STICKY_EVENT,
   input wire logic [supply_mon_pkg::SYS_EV_W-1:0] I_SYS_EVENT,
   input wire logic I_CLKWDT_EVENT,
   input wire logic I_VS_UV,
   output logic O_PREADY,
   output logic [supply_mon_pkg::DATA_W-1:0] O_PRDATA,
   output logic O_PSLVERR,
   output logic [supply_mon_pkg::SUPPLY_FLAG_W-1:0] O_SUPPLY_IRQ_STATUS,
   output logic [supply_mon_pkg::SUPPLY_FLAG_W-1:0] O_SUPPLY_STICKY_STATUS,
   output logic [supply_mon_pkg::SYS_EV_W-1:0] O_SYS_IRQ_REQ,
   output logic O_POWER_OFF,
   output logic O_VS_UV_OFF
);
   import supply_mon_pkg::*;

   bus_state_t st_q;
   bus_state_t st_d;
   logic [DATA_W-1:0] sys_en_q;
   logic [DATA_W-1:0] pwr_ctrl_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] byte_mask;
   logic hit_d;
   logic commit;
   logic wr_commit;
   logic wr_clear;
   logic [DATA_W-1:0] clear_word;
   logic [SUPPLY_FLAG_W-1:0] irq_clr;
   logic [SUPPLY_FLAG_W-1:0] sticky_clr;
   logic [SYS_EV_W-1:0] sys_clr;
   logic [SYS_EV_W-1:0] sys_flags;
   logic [SYS_EV_W-1:0] sys_en;

   // Byte strobes widened to a bit mask
   function automatic logic [DATA_W-1:0] strb_to_mask(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < STRB_W; b++)
      begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction : strb_to_mask

   // A transfer completes on the edge where the master sees our ready
   assign commit = I_PSEL & I_PENABLE & O_PREADY;
   assign wr_commit = commit & I_PWRITE;
   assign byte_mask = strb_to_mask(I_PSTRB);

   // Clear word keeps only the defined clear bits; reserved positions drop out
   assign wr_clear = wr_commit & (I_PADDR == SUPPLY_CLEAR_OFF);
   assign clear_word = wr_clear ? (I_PWDATA & byte_mask & SUPPLY_CLR_MASK) : '0;
   assign irq_clr = clear_word[IRQ_CLR_LSB +: SUPPLY_FLAG_W];
   assign sticky_clr = clear_word[STICKY_CLR_LSB +: SUPPLY_FLAG_W];
   assign sys_clr = (wr_commit && I_PADDR == SYS_STATUS_OFF) ?
                    (I_PWDATA[SYS_EN_LSB +: SYS_EV_W] & byte_mask[SYS_EN_LSB +: SYS_EV_W]) :
                    '0;
   assign sys_en = sys_en_q[SYS_EN_LSB +: SYS_EV_W];

   // Bus handshake: one wait state, ready for exactly one cycle
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
         begin
            if (I_PSEL && I_PENABLE)
               st_d = ST_ACC;
         end
         ST_ACC:
         begin
            st_d = ST_IDLE;
         end
         default:
         begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
         st_q <= ST_IDLE;
      else
         st_q <= st_d;
   end

   // Ready raised on entry to the access state so the master samples it a cycle later
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
         O_PREADY <= 1'b0;
      else
         O_PREADY <= (st_q == ST_IDLE) & I_PSEL & I_PENABLE;
   end

   // Read decode; the clear register is write-only and reads as zero
   always_comb
   begin
      rdata_d = '0;
      hit_d = 1'b1;
      case (I_PADDR)
         SUPPLY_CLEAR_OFF: rdata_d = '0;
         SYS_IRQ_EN_OFF: rdata_d = sys_en_q & SYS_EN_MASK;
         PWR_CTRL_OFF: rdata_d = pwr_ctrl_q & PWR_CTRL_MASK;
         SUPPLY_STATUS_OFF:
         begin
            rdata_d[IRQ_CLR_LSB +: SUPPLY_FLAG_W] = O_SUPPLY_IRQ_STATUS;
            rdata_d[STICKY_CLR_LSB +: SUPPLY_FLAG_W] = O_SUPPLY_STICKY_STATUS;
         end
         SYS_STATUS_OFF: rdata_d[SYS_EN_LSB +: SYS_EV_W] = sys_flags;
         default: hit_d = 1'b0;
      endcase
   end

   // Read data and error are captured together with ready and held until the next one
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_PRDATA <= '0;
         O_PSLVERR <= 1'b0;
      end
      else if ((st_q == ST_IDLE) && I_PSEL && I_PENABLE)
      begin
         O_PRDATA <= I_PWRITE ? '0 : rdata_d;
         O_PSLVERR <= ~hit_d;
      end
   end

   // Interrupt enables; only the four defined bits are stored
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
         sys_en_q <= SYS_EN_RESET;
      else if (wr_commit && I_PADDR == SYS_IRQ_EN_OFF)
         sys_en_q <= (sys_en_q & ~(byte_mask & SYS_EN_MASK))
                     | (I_PWDATA & byte_mask & SYS_EN_MASK);
   end

   // Shutdown disables; reserved reset ones are never stored, so they read zero
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
         pwr_ctrl_q <= PWR_CTRL_RESET & PWR_CTRL_MASK;
      else if (wr_commit && I_PADDR == PWR_CTRL_OFF)
         pwr_ctrl_q <= (pwr_ctrl_q & ~(byte_mask & PWR_CTRL_MASK))
                       | (I_PWDATA & byte_mask & PWR_CTRL_MASK);
   end

   // Interrupt status flags, cleared by the low half of the clear word
   status_flag_bank #(
      .WIDTH(SUPPLY_FLAG_W)
   ) u_irq_flags (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_set(I_SUPPLY_IRQ_EVENT),
      .i_clr(irq_clr),
      .o_flags(O_SUPPLY_IRQ_STATUS)
   );

   // Sticky status flags, cleared by the high half
   status_flag_bank #(
      .WIDTH(SUPPLY_FLAG_W)
   ) u_sticky_flags (
      .i_clr(sticky_clr),
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_set(I_SUPPLY_STICKY_EVENT),
      .o_flags(O_SUPPLY_STICKY_STATUS)
   );

   // System event flags behind the four enables
   status_flag_bank #(
      .WIDTH(SYS_EV_W)
   ) u_sys_flags (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_set(I_SYS_EVENT),
      .i_clr(sys_clr),
      .o_flags(sys_flags)
   );

   // Request only while flag and enable are both high; registered to keep outputs clean
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SYS_RST)
         O_SYS_IRQ_REQ <= '0;
      else
         O_SYS_IRQ_REQ <= sys_flags & sys_en;
   end

   // Power switch-off paths
   shutdown_ctrl u_shutdown (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_clkwdt_event(I_CLKWDT_EVENT),
      .i_vs_uv(I_VS_UV),
      .i_clock_watchdog_shutdown_disable(pwr_ctrl_q[CLKWDT_DIS_BIT]),
      .i_transceiver_undervolt_shutdown_disable(pwr_ctrl_q[VS_UV_DIS_BIT]),
      .o_power_off(O_POWER_OFF),
      .o_vs_uv_off(O_VS_UV_OFF)
   );

   a_core_ov_clear: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_clear && I_PWDATA[CORE_OV_IRQ_BIT] && I_PSTRB[1] && !I_SUPPLY_IRQ_EVENT[CORE_OV_IRQ_BIT])
      |=> !O_SUPPLY_IRQ_STATUS[CORE_OV_IRQ_BIT])
      else $error("core overvoltage status not cleared");

   a_ext_ov_clear: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_clear && I_PWDATA[EXT_OV_IRQ_BIT] && I_PSTRB[1] && !I_SUPPLY_IRQ_EVENT[EXT_OV_IRQ_BIT])
      |=> !O_SUPPLY_IRQ_STATUS[EXT_OV_IRQ_BIT])
      else $error("external overvoltage status not cleared");

   a_clear_reads_zero: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (commit && !I_PWRITE && I_PADDR == SUPPLY_CLEAR_OFF) |-> (O_PRDATA == '0 && !O_PSLVERR))
      else $error("clear register read not zero");

   a_low_irq_clear: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_clear && I_PSTRB[0] && I_PWDATA[7:0] == 8'hff && I_SUPPLY_IRQ_EVENT[7:0] == 8'h00)
      |=> O_SUPPLY_IRQ_STATUS[7:0] == 8'h00)
      else $error("low interrupt status not cleared");

   a_sticky_uv_clear: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_clear && I_PSTRB[2] && I_PWDATA[STICKY_CLR_LSB] && !I_SUPPLY_STICKY_EVENT[0])
      |=> !O_SUPPLY_STICKY_STATUS[0])
      else $error("battery sticky undervoltage not cleared");

   a_sticky_ov_clear: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_clear && I_PSTRB[3] && I_PWDATA[STICKY_OV_LSB + 4] && !I_SUPPLY_STICKY_EVENT[9])
      |=> !O_SUPPLY_STICKY_STATUS[9])
      else $error("external sticky overvoltage not cleared");

   a_zero_keeps_flag: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (O_SUPPLY_IRQ_STATUS[CORE_OV_IRQ_BIT] && !(wr_clear && I_PWDATA[CORE_OV_IRQ_BIT]))
      |=> O_SUPPLY_IRQ_STATUS[CORE_OV_IRQ_BIT])
      else $error("flag lost on zero write");

   a_sys_irq_gate: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      ##1 O_SYS_IRQ_REQ == ($past(sys_flags) & $past(sys_en_q[SYS_EN_LSB +: SYS_EV_W])))
      else $error("system request not flag and enable");

   a_pwr_reset_value: assert property (
      @(posedge I_CORE_CLK)
      $past(I_SYS_RST) |-> (pwr_ctrl_q == (PWR_CTRL_RESET & PWR_CTRL_MASK)))
      else $error("power control reset value wrong");

   a_ready_one_cycle: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      O_PREADY |=> !O_PREADY)
      else $error("ready held longer than one cycle");

   a_warn_irq_gate: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      sys_flags[0] |=> O_SYS_IRQ_REQ[0] == $past(sys_en[0]))
      else $error("overtemperature warning request not gated by its enable");

   a_shutdown_irq_gate: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      sys_flags[1] |=> O_SYS_IRQ_REQ[1] == $past(sys_en[1]))
      else $error("overtemperature shutdown request not gated by its enable");

   a_ref_low_gate: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      sys_flags[2] |=> O_SYS_IRQ_REQ[2] == $past(sys_en[2]))
      else $error("reference low request not gated by its enable");

   a_ref_high_gate: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      sys_flags[3] |=> O_SYS_IRQ_REQ[3] == $past(sys_en[3]))
      else $error("reference high request not gated by its enable");

   a_ready_after_wait: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (st_q == ST_IDLE && I_PSEL && I_PENABLE) |=> O_PREADY)
      else $error("ready missing after the wait state");

   a_enable_write: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_commit && I_PADDR == SYS_IRQ_EN_OFF && I_PSTRB[1])
      |=> sys_en == $past(I_PWDATA[SYS_EN_LSB +: SYS_EV_W]))
      else $error("interrupt enable write lost");

   a_wdt_disable_write: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_commit && I_PADDR == PWR_CTRL_OFF && I_PSTRB[0])
      |=> pwr_ctrl_q[CLKWDT_DIS_BIT] == $past(I_PWDATA[CLKWDT_DIS_BIT]))
      else $error("watchdog shutdown disable write lost");

   a_uv_disable_write: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (wr_commit && I_PADDR == PWR_CTRL_OFF && I_PSTRB[1])
      |=> pwr_ctrl_q[VS_UV_DIS_BIT] == $past(I_PWDATA[VS_UV_DIS_BIT]))
      else $error("undervoltage shutdown disable write lost");

   a_pwr_reserved_zero: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (pwr_ctrl_q & ~PWR_CTRL_MASK) == '0)
      else $error("power control reserved bit stored");

   a_sticky_zero_keeps: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (O_SUPPLY_STICKY_STATUS[0] && !(wr_clear && I_PWDATA[STICKY_CLR_LSB]))
      |=> O_SUPPLY_STICKY_STATUS[0])
      else $error("sticky flag lost on zero write");

   a_unmapped_error: assert property (
      @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (commit && !hit_d) |-> O_PSLVERR)
      else $error("unmapped access without error response");

endmodule : supply_monitor_irq_control_regs

// file: tb.sv
`timescale 1ns/1ns
module tb;
   import supply_mon_pkg::*;
   logic core_clk;
   logic sys_rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [STRB_W-1:0] pstrb;
   logic [SUPPLY_FLAG_W-1:0] irq_ev;
   logic [SUPPLY_FLAG_W-1:0] sticky_ev;
   logic [SYS_EV_W-1:0] sys_ev;
   logic wdt_ev;
   logic vs_uv;
   logic pready;
   logic [DATA_W-1:0] prdata;
   logic pslverr;
   logic [SUPPLY_FLAG_W-1:0] irq_st;
   logic [SUPPLY_FLAG_W-1:0] sticky_st;
   logic [SYS_EV_W-1:0] sys_req;
   logic power_off;
   logic vs_uv_off;
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] val;
   logic err;
   logic [3:0] sev;
   int mismatches;
   int samples_checked;

   supply_monitor_irq_control_regs i_supply_monitor_irq_control_regs (
      .I_CORE_CLK(core_clk), .I_SYS_RST(sys_rst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
      .I_SUPPLY_IRQ_EVENT(irq_ev), .I_SUPPLY_STICKY_EVENT(sticky_ev), .I_SYS_EVENT(sys_ev),
      .I_CLKWDT_EVENT(wdt_ev), .I_VS_UV(vs_uv), .O_PREADY(pready), .O_PRDATA(prdata),
      .O_PSLVERR(pslverr), .O_SUPPLY_IRQ_STATUS(irq_st), .O_SUPPLY_STICKY_STATUS(sticky_st),
      .O_SYS_IRQ_REQ(sys_req), .O_POWER_OFF(power_off), .O_VS_UV_OFF(vs_uv_off)
   );

   // 250 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Single comparison point, so every result is counted the same way
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Register bus results: read data and error response
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask : chk_reg

   // Status flags and interrupt requests
   task automatic chk_flag(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask : chk_flag

   // Shutdown output levels
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask : chk_pin

   task automatic tally_and_finish;
      $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   // APB transfer; waits on pready for as long as it takes, the run watchdog bounds a dead slave
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      forever
      begin
         @(posedge core_clk);
         if (pready === 1'b1)
            break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Expected flag image after a one-to-clear write onto fully set flags
   function automatic logic [31:0] exp_clear(input logic [9:0] c);
      return {22'h0, 10'h3ff & ~c};
   endfunction : exp_clear

   function automatic logic [31:0] exp_off(input logic [31:0] w);
      return {30'h0, ~w[1], ~w[8]};
   endfunction : exp_off

   // Bit mask of the byte lanes that a strobe pattern lets through
   function automatic logic [31:0] lanes(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lanes

   // A request stands only where an event flag meets its enable bit
   function automatic logic [31:0] exp_req(input logic [3:0] ev, input logic [31:0] w);
      return {28'h0, ev & w[11:8]};
   endfunction : exp_req

   function automatic logic [31:0] pick(input int i, input logic [31:0] c0, input logic [31:0] c1,
                                        input logic [31:0] c2, input logic [31:0] c3);
      case (i)
         0: return c0;
         1: return c1;
         2: return c2;
         3: return c3;
         default: return $urandom;
      endcase
   endfunction : pick

   // Watchdog on the whole run
   initial
   begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(32'h3e27));
      {sys_rst, psel, penable, pwrite, wdt_ev, vs_uv} = 6'b100000;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      irq_ev = '0;
      sticky_ev = '0;
      sys_ev = '0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Reset values, write-only clear register and an unmapped slot
      apb(1'b0, SYS_IRQ_EN_OFF, 32'h0, rd, err);
      chk_reg(rd, SYS_EN_RESET);
      apb(1'b0, PWR_CTRL_OFF, 32'h0, rd, err);
      chk_reg(rd, 32'h00000002);
      apb(1'b0, SUPPLY_CLEAR_OFF, 32'h0, rd, err);
      chk_reg(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0, rd, err);
      chk_reg({31'h0, err}, 32'h1);
      chk_reg(rd, 32'h0);
      // Supply clears: corners with all lanes, then random words under random strobes
      for (int i = 0; i < 14; i++)
      begin
         val = pick(i, 32'h0, 32'hfc00fc00, 32'h00010100, 32'h02000200);
         @(posedge core_clk);
         irq_ev <= '1;
         sticky_ev <= '1;
         pstrb <= (i < 4) ? 4'hf : 4'($urandom);
         @(posedge core_clk);
         irq_ev <= '0;
         sticky_ev <= '0;
         apb(1'b1, SUPPLY_CLEAR_OFF, val, rd, err);
         val = val & lanes(pstrb);
         @(negedge core_clk);
         chk_flag({22'h0, irq_st}, exp_clear(val[9:0]));
         chk_flag({22'h0, sticky_st}, exp_clear(val[25:16]));
         apb(1'b0, SUPPLY_STATUS_OFF, 32'h0, rd, err);
         chk_reg(rd, (exp_clear(val[25:16]) << 16) | exp_clear(val[9:0]));
      end
      @(posedge core_clk);
      pstrb <= 4'hf;
      // System enables gate the requests; flags hold until cleared
      for (int i = 0; i < 10; i++)
      begin
         val = pick(i, 32'h100, 32'h200, 32'h400, 32'h800);
         apb(1'b1, SYS_IRQ_EN_OFF, val, rd, err);
         apb(1'b0, SYS_IRQ_EN_OFF, 32'h0, rd, err);
         chk_reg(rd, val & SYS_EN_MASK);
         sev = (i < 4) ? 4'hf : 4'($urandom);
         @(posedge core_clk);
         sys_ev <= sev;
         @(posedge core_clk);
         sys_ev <= '0;
         repeat (4) @(posedge core_clk);
         @(negedge core_clk);
         chk_flag({28'h0, sys_req}, exp_req(sev, val));
         apb(1'b0, SYS_STATUS_OFF, 32'h0, rd, err);
         chk_reg(rd, {20'h0, sev, 8'h0});
         apb(1'b1, SYS_STATUS_OFF, 32'h00000f00, rd, err);
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk_flag({28'h0, sys_req}, 32'h0);
      end
      // Shutdown disables against both fault inputs
      for (int i = 0; i < 8; i++)
      begin
         val = pick(i, 32'h0, 32'h2, 32'h100, 32'hffffffff);
         apb(1'b1, PWR_CTRL_OFF, val, rd, err);
         apb(1'b0, PWR_CTRL_OFF, 32'h0, rd, err);
         chk_reg(rd, val & PWR_CTRL_MASK);
         @(posedge core_clk);
         wdt_ev <= 1'b1;
         vs_uv <= 1'b1;
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk_pin({30'h0, power_off, vs_uv_off}, exp_off(val));
         @(posedge core_clk);
         wdt_ev <= 1'b0;
         vs_uv <= 1'b0;
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk_pin({30'h0, power_off, vs_uv_off}, 32'h0);
      end
      // Reset in mid-run brings the stored controls back to their reset image
      apb(1'b1, PWR_CTRL_OFF, 32'h00000100, rd, err);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      apb(1'b0, PWR_CTRL_OFF, 32'h0, rd, err);
      chk_reg(rd, 32'h00000002);
      apb(1'b0, SYS_IRQ_EN_OFF, 32'h0, rd, err);
      chk_reg(rd, SYS_EN_RESET);
      tally_and_finish();
   end
endmodule : tb
